// ==== core/external_pin_interrupts.sv ====
// external pin and pin-change interrupt controller with an axi4-lite register slave
`timescale 1ns/1ps
`include "ext_irq_regs.svh"

module external_pin_interrupts #(
	parameter int ADDR_WIDTH = 12
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// pads
	input wire logic ext_irq_pin,
	input wire logic [ext_irq_pkg::PIN_COUNT-1:0] pin_change_inputs,
	// cpu core
	input wire logic global_irq_enable,
	input wire logic [3:0] irq_ack,
	output ext_irq_pkg::irq_out_s irq_out
);
	import ext_irq_pkg::*;

	state_s s;
	state_s next_s;
	sense_e sense;
	logic ext_rise;
	logic ext_fall;
	logic ext_event;
	logic wr_now;
	logic [PIN_COUNT-1:0] pin_mask;
	logic [PIN_COUNT-1:0] pc_change;
	logic [2:0] grp_set;
	logic [3:0] set_bits;
	logic [3:0] clr_bits;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic wr_hit;

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign awready = s.awready;
	assign wready = s.wready;
	assign arready = s.arready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign irq_out = s.irq;

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb begin
		next_s = s;
		wr_now = s.aw_held && s.w_held && !s.bvalid;
		wr_hit = 1'b0;
		clr_bits = 4'h0;

		// register write, once address and data are both held
		if (wr_now) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			unique case (s.aw_idx)
				`IDX_MASK_GROUP0,
				`IDX_MASK_GROUP1,
				`IDX_MASK_GROUP2,
				`IDX_FLAGS,
				`IDX_ENABLE,
				`IDX_CONTROL: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
			next_s.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			if (wr_hit && s.w_lane) begin
				unique case (s.aw_idx)
					`IDX_MASK_GROUP0: next_s.mask0 = s.w_byte & `USED_MASK_GROUP0;
					`IDX_MASK_GROUP1: next_s.mask1 = s.w_byte & `USED_MASK_GROUP1;
					`IDX_MASK_GROUP2: next_s.mask2 = s.w_byte & `USED_MASK_GROUP2;
					`IDX_ENABLE: next_s.enable = s.w_byte & `USED_ENABLE;
					`IDX_CONTROL: next_s.control = s.w_byte & `USED_CONTROL;
					`IDX_FLAGS: begin
						// write one to clear
						clr_bits = {s.w_byte[`BIT_GROUP2], s.w_byte[`BIT_GROUP1],
							s.w_byte[`BIT_GROUP0], s.w_byte[`BIT_EXT]};
					end
					default: clr_bits = 4'h0;
				endcase
			end
		end

		// write channels
		if (awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_idx = awaddr[9:2];
		end
		if (wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.w_byte = wdata[7:0];
			next_s.w_lane = wstrb[0];
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// read channels
		rd_hit = 1'b1;
		unique case (araddr[9:2])
			`IDX_MASK_GROUP0: rd_byte = s.mask0;
			`IDX_MASK_GROUP1: rd_byte = s.mask1;
			`IDX_MASK_GROUP2: rd_byte = s.mask2;
			`IDX_ENABLE: rd_byte = s.enable;
			`IDX_CONTROL: rd_byte = s.control;
			`IDX_FLAGS: begin
				rd_byte = 8'h00;
				rd_byte[`BIT_EXT] = s.flags[0];
				rd_byte[`BIT_GROUP0] = s.flags[1];
				rd_byte[`BIT_GROUP1] = s.flags[2];
				rd_byte[`BIT_GROUP2] = s.flags[3];
			end
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = {24'h000000, rd_byte};
			next_s.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;

		// pad sampling, independent of pad direction
		next_s.ext_sample = ext_irq_pin;
		next_s.ext_prev = s.ext_sample;
		next_s.pin_prev = pin_change_inputs;
		next_s.primed = {s.primed[0], 1'b1};

		// dedicated pin sense decode
		sense = sense_e'(s.control[`SENSE_MSB:`SENSE_LSB]);
		ext_rise = s.primed[1] && s.ext_sample && !s.ext_prev;
		ext_fall = s.primed[1] && !s.ext_sample && s.ext_prev;
		unique case (sense)
			SENSE_LOW: ext_event = 1'b0;
			SENSE_ANY: ext_event = ext_rise || ext_fall;
			SENSE_FALL: ext_event = ext_fall;
			SENSE_RISE: ext_event = ext_rise;
		endcase

		// pin-change groups
		pin_mask = {s.mask2[5:0], s.mask1[3:0], s.mask0};
		pc_change = (pin_change_inputs ^ s.pin_prev) & pin_mask & {PIN_COUNT{s.primed[0]}};
		grp_set[0] = |pc_change[7:0];
		grp_set[1] = |pc_change[11:8];
		grp_set[2] = |pc_change[17:12];

		// flags: a set in the same cycle as a clear wins
		set_bits = {grp_set, ext_event};
		clr_bits = clr_bits | irq_ack;
		next_s.flags = (s.flags & ~clr_bits) | set_bits;
		if (sense_e'(next_s.control[`SENSE_MSB:`SENSE_LSB]) == SENSE_LOW) begin
			next_s.flags[0] = 1'b0;
		end

		// requests toward the core
		if (sense_e'(next_s.control[`SENSE_MSB:`SENSE_LSB]) == SENSE_LOW) begin
			// live level: a vanished level leaves no request behind
			next_s.irq.req[0] = global_irq_enable && next_s.enable[`BIT_EXT]
				&& !ext_irq_pin;
		end else begin
			next_s.irq.req[0] = global_irq_enable && next_s.enable[`BIT_EXT]
				&& next_s.flags[0];
		end
		next_s.irq.req[1] = global_irq_enable && next_s.enable[`BIT_GROUP0]
			&& next_s.flags[1];
		next_s.irq.req[2] = global_irq_enable && next_s.enable[`BIT_GROUP1]
			&& next_s.flags[2];
		next_s.irq.req[3] = global_irq_enable && next_s.enable[`BIT_GROUP2]
			&& next_s.flags[3];

		// wake does not wait for the global flag
		next_s.irq.wake = (next_s.enable[`BIT_EXT] && !ext_irq_pin
			&& sense_e'(next_s.control[`SENSE_MSB:`SENSE_LSB]) == SENSE_LOW)
			|| (next_s.enable[`BIT_GROUP0] && next_s.flags[1])
			|| (next_s.enable[`BIT_GROUP1] && next_s.flags[2])
			|| (next_s.enable[`BIT_GROUP2] && next_s.flags[3]);
	end

	// ----------------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	a_level_flag_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.control[`SENSE_MSB:`SENSE_LSB] == 2'b00) |-> !s.flags[0])
		else $error("ext flag set in low-level mode");

	a_group0_set: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && s.primed[0] && |((pin_change_inputs[7:0] ^ s.pin_prev[7:0]) & s.mask0))
		|=> s.flags[1])
		else $error("group 0 toggle did not set flag");

	a_group1_set: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && s.primed[0]
			&& |((pin_change_inputs[11:8] ^ s.pin_prev[11:8]) & s.mask1[3:0]))
		|=> s.flags[2])
		else $error("group 1 toggle did not set flag");

	a_group2_set: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && s.primed[0]
			&& |((pin_change_inputs[17:12] ^ s.pin_prev[17:12]) & s.mask2[5:0]))
		|=> s.flags[3])
		else $error("group 2 toggle did not set flag");

	a_global_gate: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && !global_irq_enable) |=> (s.irq.req == 4'h0))
		else $error("request raised with global flag clear");

	a_group_enable: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s.irq.req[3:1] != 3'b000 |-> ((s.irq.req[3:1] & ~{s.enable[`BIT_GROUP2],
			s.enable[`BIT_GROUP1], s.enable[`BIT_GROUP0]}) == 3'b000)
			&& ((s.irq.req[3:1] & ~s.flags[3:1]) == 3'b000))
		else $error("group request without enable and flag");

	a_ext_enable: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s.irq.req[0] |-> s.enable[`BIT_EXT])
		else $error("ext request without enable");

	a_level_request: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && global_irq_enable && s.enable[`BIT_EXT] && !ext_irq_pin && !wr_now
			&& s.control[`SENSE_MSB:`SENSE_LSB] == 2'b00) |=> s.irq.req[0])
		else $error("low level not requesting");

	a_rise_edge: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && !wr_now && s.primed[1] && s.control[`SENSE_MSB:`SENSE_LSB] == 2'b11
			&& s.ext_sample && !s.ext_prev) |=> s.flags[0])
		else $error("rising edge missed");

	a_write_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_now && s.w_lane && s.aw_idx == `IDX_FLAGS && s.w_byte[`BIT_GROUP0])
		|=> (s.flags[1] == $past(grp_set[0])))
		else $error("write one did not clear group 0 flag");

	a_ack_set_wins: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && irq_ack[1] && grp_set[0]) |=> s.flags[1])
		else $error("set lost against acknowledge");

	a_reserved_zero: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && arvalid && s.arready && araddr[9:2] == `IDX_MASK_GROUP2)
		|=> (s.rdata[7:6] == 2'b00) && s.rvalid)
		else $error("reserved bits read non-zero");

	a_bresp_order: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.bvalid && !$past(s.bvalid)) |-> $past(wr_now))
		else $error("write response before address and data");

	a_ce_freeze: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!ce |=> $stable(s))
		else $error("state moved with clock enable low");

	a_fall_edge: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && !wr_now && s.primed[1] && s.control[`SENSE_MSB:`SENSE_LSB] == 2'b10
			&& !s.ext_sample && s.ext_prev) |=> s.flags[0])
		else $error("falling edge missed");

	a_any_change: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && !wr_now && s.primed[1] && s.control[`SENSE_MSB:`SENSE_LSB] == 2'b01
			&& (s.ext_sample != s.ext_prev)) |=> s.flags[0])
		else $error("change missed in any-change mode");

	a_no_edge_quiet: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && !wr_now && (s.ext_sample == s.ext_prev) && !s.flags[0]) |=> !s.flags[0])
		else $error("ext flag set without a sampled edge");

	a_level_release: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && ext_irq_pin && !wr_now && s.control[`SENSE_MSB:`SENSE_LSB] == 2'b00)
		|=> !s.irq.req[0])
		else $error("request left after low level vanished");

	a_level_wake: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && s.enable[`BIT_EXT] && !ext_irq_pin && !wr_now
			&& s.control[`SENSE_MSB:`SENSE_LSB] == 2'b00) |=> s.irq.wake)
		else $error("low level gave no wake");

	a_group_wake: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s.enable[`BIT_GROUP0] && s.flags[1]) |-> s.irq.wake)
		else $error("pending group 0 change gave no wake");

	a_masked_quiet: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && !wr_now && s.mask0 == 8'h00 && !s.flags[1]) |=> !s.flags[1])
		else $error("group 0 flag set with all inputs masked");

	a_ack_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(ce && irq_ack[1] && !grp_set[0]) |=> !s.flags[1])
		else $error("service did not clear group 0 flag");

	a_rdata_upper: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s.rvalid |-> (s.rdata[31:8] == 24'h000000))
		else $error("read data upper bytes non-zero");

endmodule // external_pin_interrupts

// ==== core/ext_irq_regs.svh ====
// register indices, field positions and reset values of the external interrupt block
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_MASK_GROUP0 8'h09
`define IDX_MASK_GROUP1 8'h0A
`define IDX_FLAGS 8'h0B
`define IDX_ENABLE 8'h0C
`define IDX_MASK_GROUP2 8'h1A
`define IDX_CONTROL 8'h20

// ----------------------------------------------------------------------
// field positions in the enable, flag and control registers
// ----------------------------------------------------------------------
`define BIT_EXT 0
`define BIT_GROUP0 4
`define BIT_GROUP1 5
`define BIT_GROUP2 6
`define SENSE_MSB 7
`define SENSE_LSB 6

// ----------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------
`define USED_ENABLE 8'h71
`define USED_MASK_GROUP0 8'hFF
`define USED_MASK_GROUP1 8'h0F
`define USED_MASK_GROUP2 8'h3F
`define USED_CONTROL 8'hC0
`define RESET_BYTE 8'h00

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== core/ext_irq_pkg.sv ====
// types shared by the external interrupt block
package ext_irq_pkg;

	localparam int PIN_COUNT = 18;

	typedef enum logic [1:0] {
		SENSE_LOW,
		SENSE_ANY,
		SENSE_FALL,
		SENSE_RISE
	} sense_e;

	// requests toward the cpu core: 0 ext pin, 1..3 change groups 0..2
	typedef struct packed {
		logic [3:0] req;
		logic wake;
	} irq_out_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_held;
		logic [7:0] aw_idx;
		logic w_held;
		logic [7:0] w_byte;
		logic w_lane;
		logic [7:0] mask0;
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] enable;
		logic [7:0] control;
		logic [3:0] flags;
		logic ext_sample;
		logic ext_prev;
		logic [PIN_COUNT-1:0] pin_prev;
		logic [1:0] primed;
		irq_out_s irq;
	} state_s;

endpackage

// ==== bench/pad_cpu_model.sv ====
// pad and cpu-core model on the far side of the interrupt block
`timescale 1ns/1ps

module pad_cpu_model (
	// clock
	input wire logic aclk,
	// pads and cpu core
	output logic ext_irq_pin,
	output logic [ext_irq_pkg::PIN_COUNT-1:0] pin_change_inputs,
	output logic global_irq_enable,
	output logic [3:0] irq_ack
);
	import ext_irq_pkg::*;

	initial begin
		ext_irq_pin = 1'b1;
		pin_change_inputs = '0;
		global_irq_enable = 1'b0;
		irq_ack = 4'h0;
	end

	// pads driven as outputs still count as activity
	task automatic drive_ext(input logic v);
		@(posedge aclk);
		ext_irq_pin <= v;
		repeat (4) @(posedge aclk); // level held past one clock and the instruction
	endtask

	task automatic toggle(input int p);
		@(posedge aclk);
		pin_change_inputs[p] <= ~pin_change_inputs[p];
		repeat (3) @(posedge aclk);
	endtask

	task automatic set_gie(input logic v);
		@(posedge aclk);
		global_irq_enable <= v;
		repeat (2) @(posedge aclk);
	endtask

	// one-cycle service pulse, as on vector entry
	task automatic service(input int s);
		@(posedge aclk);
		irq_ack[s] <= 1'b1;
		@(posedge aclk);
		irq_ack <= 4'h0;
		repeat (2) @(posedge aclk);
	endtask
endmodule // pad_cpu_model

// ==== bench/testbench.sv ====
// self-checking testbench of the external pin interrupt block
`timescale 1ns/1ps
`include "ext_irq_regs.svh"

module testbench;
	import ext_irq_pkg::*;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic ce = 1'b1, wlane = 1'b1;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [3:0] wstrb = 4'hF;
	logic ext_irq_pin, global_irq_enable;
	logic [PIN_COUNT-1:0] pin_change_inputs;
	logic [3:0] irq_ack;
	irq_out_s irq_out;
	logic [33:0] expq[$];
	logic [7:0] idxs[6] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h1A, 8'h20};
	logic [7:0] used[6] = '{8'hFF, 8'h0F, 8'h00, 8'h71, 8'h3F, 8'hC0};
	logic [7:0] mi;
	int fails = 0;
	int tests_run = 0;
	int g, p, b, s;

	always #5 aclk = ~aclk;

	external_pin_interrupts external_pin_interrupts_inst (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs),
		.global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq_out(irq_out));

	pad_cpu_model pad_cpu_model_inst (.aclk(aclk), .ext_irq_pin(ext_irq_pin),
		.pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable),
		.irq_ack(irq_ack));

	task automatic results;
		if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic miss(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
		int n;
		expq.push_back({r, 32'h00000000});
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= {3'($urandom), wlane};
		awprot <= 3'($urandom);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		if (bvalid !== 1'b1) begin
			miss("write hung");
			results();
		end
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
		int n;
		expq.push_back({r, 24'h000000, d});
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arprot <= 3'($urandom);
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		if (rvalid !== 1'b1) begin
			miss("read hung");
			results();
		end
	endtask

	task automatic chk(input logic [4:0] e, input string m);
		#1;
		tests_run++;
		if (irq_out !== e) miss(m);
	endtask

	// answer watcher: oldest note against each bus answer
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			tests_run++;
			if (expq.size() == 0) miss("unexpected bus answer");
			else if ((bvalid ? {bresp, 32'h0} : {rresp, rdata}) !== expq.pop_front())
				miss("bus answer differs");
		end
	end

	initial begin
		void'($urandom(89));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		// ----------------------------------------------------------------
		// reset values, reserved bits, unmapped place
		// ----------------------------------------------------------------
		for (int i = 0; i < 6; i++) begin
			rd(idxs[i], 8'h00, `RESP_OKAY);
			wr(idxs[i], 8'hFF, `RESP_OKAY);
			rd(idxs[i], used[i], `RESP_OKAY);
			wr(idxs[i], (i == 3) ? 8'h71 : 8'h00, `RESP_OKAY);
		end
		wr(8'h30, 8'hFF, `RESP_SLVERR);
		rd(8'h30, 8'h00, `RESP_SLVERR);
		wlane = 1'b0;
		wr(`IDX_MASK_GROUP0, 8'hFF, `RESP_OKAY);
		wlane = 1'b1;
		rd(`IDX_MASK_GROUP0, 8'h00, `RESP_OKAY);
		pad_cpu_model_inst.set_gie(1'b1);
		// ----------------------------------------------------------------
		// pin-change groups: masked, merged, gated, serviced
		// ----------------------------------------------------------------
		for (g = 0; g < 3; g++) begin
			mi = (g == 0) ? `IDX_MASK_GROUP0 : (g == 1) ? `IDX_MASK_GROUP1 : `IDX_MASK_GROUP2;
			b = (g == 0) ? 0 : (g == 1) ? 8 : 12;
			p = b + $urandom % ((g == 0) ? 8 : (g == 1) ? 4 : 6);
			pad_cpu_model_inst.toggle(p);
			rd(`IDX_FLAGS, 8'h00, `RESP_OKAY);
			wr(mi, 8'h01 << (p - b), `RESP_OKAY);
			pad_cpu_model_inst.toggle(p);
			pad_cpu_model_inst.toggle(p);
			rd(`IDX_FLAGS, 8'h01 << (4 + g), `RESP_OKAY);
			chk({4'h1 << (g + 1), 1'b1}, "group request");
			pad_cpu_model_inst.set_gie(1'b0);
			chk({4'h0, 1'b1}, "global gate");
			pad_cpu_model_inst.set_gie(1'b1);
			ce <= 1'b0;
			pad_cpu_model_inst.service(g + 1);
			chk({4'h1 << (g + 1), 1'b1}, "frozen by clock enable");
			@(posedge aclk);
			ce <= 1'b1;
			pad_cpu_model_inst.service(g + 1);
			chk(5'h00, "service clear");
			wr(mi, 8'h00, `RESP_OKAY);
		end
		// ----------------------------------------------------------------
		// sense modes of the dedicated pin
		// ----------------------------------------------------------------
		wr(`IDX_ENABLE, 8'h01, `RESP_OKAY);
		for (s = 1; s < 4; s++) begin
			wr(`IDX_CONTROL, {s[1:0], 6'h00}, `RESP_OKAY);
			pad_cpu_model_inst.drive_ext(1'b0);
			rd(`IDX_FLAGS, {7'h00, s != 3}, `RESP_OKAY);
			wr(`IDX_FLAGS, 8'h01, `RESP_OKAY);
			pad_cpu_model_inst.drive_ext(1'b1);
			rd(`IDX_FLAGS, {7'h00, s != 2}, `RESP_OKAY);
			wr(`IDX_FLAGS, 8'h01, `RESP_OKAY);
		end
		wr(`IDX_CONTROL, 8'h00, `RESP_OKAY);
		pad_cpu_model_inst.drive_ext(1'b0);
		chk({4'h1, 1'b1}, "low level request");
		rd(`IDX_FLAGS, 8'h00, `RESP_OKAY);
		chk({4'h1, 1'b1}, "low level held");
		pad_cpu_model_inst.set_gie(1'b0);
		chk({4'h0, 1'b1}, "low level gated");
		pad_cpu_model_inst.set_gie(1'b1);
		pad_cpu_model_inst.drive_ext(1'b1);
		chk(5'h00, "low level released");
		wr(`IDX_MASK_GROUP1, 8'h0F, `RESP_OKAY);
		pad_cpu_model_inst.toggle(9);
		rd(`IDX_FLAGS, 8'h20, `RESP_OKAY);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(5'h00, "reset clears requests");
		for (int i = 0; i < 6; i++) rd(idxs[i], 8'h00, `RESP_OKAY);
		results();
	end
endmodule // testbench
